// ### inc/ofs_pkg.sv
// Constants shared by the output function selector block.
package ofs_pkg;

   // Register bus geometry.
   localparam int            ADDR_W = 4;
   localparam int            DATA_W = 8;

   // Register addresses on the plain register port.
   localparam logic [3:0]    ADDR_SEL_FIRST  = 4'h0;
   localparam logic [3:0]    ADDR_SEL_SECOND = 4'h1;
   localparam logic [3:0]    ADDR_INT_STATUS = 4'h2;
   localparam logic [3:0]    ADDR_INT_MASK   = 4'h3;
   localparam logic [3:0]    ADDR_OUT_STATE  = 4'h4;

   // Reset values.
   localparam logic [4:0]    RST_SEL_FIRST   = 5'h00;
   localparam logic [4:0]    RST_SEL_SECOND  = 5'h01;
   localparam logic [2:0]    RST_INT_MASK    = 3'h0;

   // Interrupt status and mask field positions.
   localparam int            INT_FIRST_RISE  = 0;
   localparam int            INT_SECOND_RISE = 1;
   localparam int            INT_REJECT      = 2;
   localparam int            INT_W           = 3;

   // Output state register field positions.
   localparam int            ST_FIRST        = 0;
   localparam int            ST_SECOND       = 1;
   localparam int            ST_PHASE_PULSE  = 2;
   localparam int            ST_CYCLE_PULSE  = 3;

   // Output function codes.
   localparam logic [4:0]    FN_NONE         = 5'h00;
   localparam logic [4:0]    FN_RUN          = 5'h01;
   localparam logic [4:0]    FN_FREQ_REACHED = 5'h02;
   localparam logic [4:0]    FN_LEVEL_ONE    = 5'h03;
   localparam logic [4:0]    FN_LEVEL_TWO    = 5'h04;
   localparam logic [4:0]    FN_OVERLOAD     = 5'h05;
   localparam logic [4:0]    FN_UNDERVOLT    = 5'h06;
   localparam logic [4:0]    FN_EXT_FAULT    = 5'h07;
   localparam logic [4:0]    FN_UPPER_LIMIT  = 5'h08;
   localparam logic [4:0]    FN_LOWER_LIMIT  = 5'h09;
   localparam logic [4:0]    FN_ZERO_FREQ    = 5'h0a;
   localparam logic [4:0]    FN_PHASE_DONE   = 5'h0b;
   localparam logic [4:0]    FN_CYCLE_DONE   = 5'h0c;
   localparam logic [4:0]    FN_SET_COUNT    = 5'h0d;
   localparam logic [4:0]    FN_SPEC_COUNT   = 5'h0e;
   localparam logic [4:0]    FN_LENGTH       = 5'h0f;
   localparam logic [4:0]    FN_READY        = 5'h10;
   localparam logic [4:0]    FN_FAULT        = 5'h11;
   localparam logic [4:0]    FN_RESERVED_A   = 5'h12;
   localparam logic [4:0]    FN_RUN_TIME     = 5'h13;
   localparam logic [4:0]    FN_FORWARD      = 5'h14;
   localparam logic [4:0]    FN_REVERSE      = 5'h15;
   localparam logic [4:0]    FN_RESERVED_B   = 5'h16;
   localparam logic [4:0]    FN_SLEEP        = 5'h17;
   localparam logic [4:0]    FN_OVERPRESSURE = 5'h18;
   localparam logic [4:0]    FN_UNDERPRESS   = 5'h19;
   localparam logic [4:0]    FN_PIPE_SHORT   = 5'h1a;
   localparam logic [4:0]    FN_TANK_SHORT   = 5'h1b;
   localparam logic [4:0]    FN_PIPE_BURST   = 5'h1c;
   localparam logic [4:0]    FN_MAX          = FN_PIPE_BURST;

   // Width of the length and running-time quantities.
   localparam int            VAL_W = 16;

   // Timing: the completion pulse width and the clock rate.
   localparam int            PLC_PULSE_MS   = 250;
   localparam int            CLK_HZ         = 100_000_000;
   localparam int            PLC_PULSE_CYC  = PLC_PULSE_MS * (CLK_HZ / 1000);
   localparam int            PULSE_CNT_W    = 25;

endpackage : ofs_pkg

// ### hdl/ofs_output_function_selector.sv
// Output function selector driving the two open-collector outputs.
//
// Operation
// - Each output follows its selected condition; code 1 shows running.
// - Codes 2 to 12 select frequency, level, fault, limit, PLC signals.
// - Codes 13 and 14 select set-count and specified-count reached.
// - Code 15 asserts while measured length is at least set length.
// - Code 16 asserts when no fault, bus normal and run not prohibited.
// - Code 17 asserts while the drive is faulted.
// - Code 19 asserts once running time reaches the cutoff time.
// - Code 20 asserts while running forward.
// - Code 21 asserts while running in reverse.
// - Code 23 asserts while sleeping in water-supply operation.
// - Code 24 asserts while pipe overpressure is judged.
// - Code 25 asserts while pipe under-pressure is judged.
// - Code 26 asserts while the pipe is short of water.
// - Code 27 asserts while a tank water shortage is detected.
// - Code 28 asserts while a pipe burst is detected.
// - Phase and cycle completion are single 250 ms pulses.
`timescale 1ns/1ps
module ofs_output_function_selector
   import ofs_pkg::*;
#(
   parameter int PULSE_CYCLES = PLC_PULSE_CYC
) (
   input  wire logic              clk_i,
   input  wire logic              resetn_i,
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic [DATA_W-1:0] reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic      [DATA_W-1:0] reg_rdata_o,
   input  wire logic              drive_running_i,
   input  wire logic              freq_reached_flag_i,
   input  wire logic              freq_level_detect_one_i,
   input  wire logic              freq_level_detect_two_i,
   input  wire logic              overload_flag_i,
   input  wire logic              undervoltage_lockout_flag_i,
   input  wire logic              external_fault_flag_i,
   input  wire logic              freq_upper_limit_flag_i,
   input  wire logic              freq_lower_limit_flag_i,
   input  wire logic              zero_freq_running_i,
   input  wire logic              phase_done_event_i,
   input  wire logic              cycle_done_event_i,
   input  wire logic              set_count_reached_i,
   input  wire logic              spec_count_reached_i,
   input  wire logic [VAL_W-1:0]  measured_length_value_i,
   input  wire logic [VAL_W-1:0]  set_length_param_i,
   input  wire logic              drive_fault_i,
   input  wire logic              bus_voltage_ok_i,
   input  wire logic              run_prohibit_i,
   input  wire logic [VAL_W-1:0]  accumulated_run_time_i,
   input  wire logic [VAL_W-1:0]  run_cutoff_time_param_i,
   input  wire logic              forward_running_i,
   input  wire logic              reverse_running_i,
   input  wire logic              supply_sleep_i,
   input  wire logic              pipe_overpressure_i,
   input  wire logic              pipe_underpressure_i,
   input  wire logic              pipe_short_i,
   input  wire logic              tank_short_i,
   input  wire logic              pipe_burst_i,
   output logic                   first_open_collector_output_o,
   output logic                   first_open_collector_output_oen_o,
   output logic                   second_open_collector_output_o,
   output logic                   second_open_collector_output_oen_o,
   output logic                   irq_o
);

   // Selection registers, one per output.
   logic [4:0]          sel_reg [2];
   // Registered state of each output, high when the transistor conducts.
   logic [1:0]          active_reg;
   logic [1:0]          active_next;
   // Completion pulse stretchers: index 0 phase, index 1 cycle.
   logic [1:0]          pulse_reg;
   logic [PULSE_CNT_W-1:0] pulse_cnt_reg [2];
   logic [1:0]          pulse_event;
   // Interrupt status and mask.
   logic [INT_W-1:0]    int_status_reg;
   logic [INT_W-1:0]    int_mask_reg;
   logic [INT_W-1:0]    int_event;
   // Condition vector indexed by function code.
   logic [31:0]         cond;
   logic                wr_sel_first;
   logic                wr_sel_second;
   logic                wr_reject;
   logic [PULSE_CNT_W-1:0] pulse_last;

   assign pulse_last  = PULSE_CNT_W'(PULSE_CYCLES - 1);
   assign pulse_event = {cycle_done_event_i, phase_done_event_i};

   // Write decode; codes above the top function are refused outright.
   assign wr_sel_first  = reg_wr_i && (reg_addr_i == ADDR_SEL_FIRST);
   assign wr_sel_second = reg_wr_i && (reg_addr_i == ADDR_SEL_SECOND);
   assign wr_reject     = (wr_sel_first || wr_sel_second) &&
                          (reg_wdata_i[4:0] > FN_MAX ||
                           reg_wdata_i[7:5] != 3'h0);

   // Function selection registers keep their value on a refused write.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         sel_reg[0] <= RST_SEL_FIRST;
         sel_reg[1] <= RST_SEL_SECOND;
      end else if (!wr_reject) begin
         if (wr_sel_first) begin
            sel_reg[0] <= reg_wdata_i[4:0];
         end
         if (wr_sel_second) begin
            sel_reg[1] <= reg_wdata_i[4:0];
         end
      end
   end

   // Completion indications leave as one fixed-width pulse each. A new
   // event during a pulse is ignored so the width never stretches.
   generate
      for (genvar p = 0; p < 2; p++) begin : g_pulse
         always_ff @(posedge clk_i) begin
            if (!resetn_i) begin
               pulse_reg[p]     <= 1'b0;
               pulse_cnt_reg[p] <= '0;
            end else if (!pulse_reg[p]) begin
               if (pulse_event[p]) begin
                  pulse_reg[p]     <= 1'b1;
                  pulse_cnt_reg[p] <= '0;
               end
            end else if (pulse_cnt_reg[p] == pulse_last) begin
               pulse_reg[p]     <= 1'b0;
               pulse_cnt_reg[p] <= '0;
            end else begin
               pulse_cnt_reg[p] <= pulse_cnt_reg[p] + 1'b1;
            end
         end
      end
   endgenerate

   // Every function code maps to one condition; unused codes stay low.
   always_comb begin
      cond                  = 32'h0000_0000;
      cond[FN_RUN]          = drive_running_i;
      cond[FN_FREQ_REACHED] = freq_reached_flag_i;
      cond[FN_LEVEL_ONE]    = freq_level_detect_one_i;
      cond[FN_LEVEL_TWO]    = freq_level_detect_two_i;
      cond[FN_OVERLOAD]     = overload_flag_i;
      cond[FN_UNDERVOLT]    = undervoltage_lockout_flag_i;
      cond[FN_EXT_FAULT]    = external_fault_flag_i;
      cond[FN_UPPER_LIMIT]  = freq_upper_limit_flag_i;
      cond[FN_LOWER_LIMIT]  = freq_lower_limit_flag_i;
      cond[FN_ZERO_FREQ]    = zero_freq_running_i;
      cond[FN_PHASE_DONE]   = pulse_reg[0];
      cond[FN_CYCLE_DONE]   = pulse_reg[1];
      cond[FN_SET_COUNT]    = set_count_reached_i;
      cond[FN_SPEC_COUNT]   = spec_count_reached_i;
      cond[FN_LENGTH]       = measured_length_value_i >=
                              set_length_param_i;
      cond[FN_READY]        = !drive_fault_i && bus_voltage_ok_i &&
                              !run_prohibit_i;
      cond[FN_FAULT]        = drive_fault_i;
      cond[FN_RUN_TIME]     = accumulated_run_time_i >=
                              run_cutoff_time_param_i;
      cond[FN_FORWARD]      = forward_running_i;
      cond[FN_REVERSE]      = reverse_running_i;
      cond[FN_SLEEP]        = supply_sleep_i;
      cond[FN_OVERPRESSURE] = pipe_overpressure_i;
      cond[FN_UNDERPRESS]   = pipe_underpressure_i;
      cond[FN_PIPE_SHORT]   = pipe_short_i;
      cond[FN_TANK_SHORT]   = tank_short_i;
      cond[FN_PIPE_BURST]   = pipe_burst_i;
   end

   // Each output takes its selected condition; registering it keeps the
   // pins glitch free while comparators and selections settle.
   generate
      for (genvar o = 0; o < 2; o++) begin : g_out
         assign active_next[o] = cond[sel_reg[o]];
         always_ff @(posedge clk_i) begin
            if (!resetn_i) begin
               active_reg[o] <= 1'b0;
            end else begin
               active_reg[o] <= active_next[o];
            end
         end
      end
   endgenerate

   // Open collector: the pin is only ever pulled low, enable is active low.
   assign first_open_collector_output_o      = 1'b0;
   assign first_open_collector_output_oen_o  = !active_reg[0];
   assign second_open_collector_output_o     = 1'b0;
   assign second_open_collector_output_oen_o = !active_reg[1];

   // Interrupt events: output switching on, and a refused write.
   assign int_event[INT_FIRST_RISE]  = active_next[0] && !active_reg[0];
   assign int_event[INT_SECOND_RISE] = active_next[1] && !active_reg[1];
   assign int_event[INT_REJECT]      = wr_reject;

   // Sticky status, write one to clear; a new event wins over the clear.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         int_status_reg <= '0;
      end else if (reg_wr_i && reg_addr_i == ADDR_INT_STATUS) begin
         int_status_reg <= (int_status_reg & ~reg_wdata_i[INT_W-1:0]) |
                           int_event;
      end else begin
         int_status_reg <= int_status_reg | int_event;
      end
   end

   // Interrupt mask.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         int_mask_reg <= RST_INT_MASK;
      end else if (reg_wr_i && reg_addr_i == ADDR_INT_MASK) begin
         int_mask_reg <= reg_wdata_i[INT_W-1:0];
      end
   end

   assign irq_o = |(int_status_reg & int_mask_reg);

   // Read data stand for one cycle after the strobe and are zero otherwise.
   always_ff @(posedge clk_i) begin
      if (!resetn_i || !reg_rd_i) begin
         reg_rdata_o <= '0;
      end else begin
         unique case (reg_addr_i)
            ADDR_SEL_FIRST:  reg_rdata_o <= {3'h0, sel_reg[0]};
            ADDR_SEL_SECOND: reg_rdata_o <= {3'h0, sel_reg[1]};
            ADDR_INT_STATUS: reg_rdata_o <= {5'h00, int_status_reg};
            ADDR_INT_MASK:   reg_rdata_o <= {5'h00, int_mask_reg};
            ADDR_OUT_STATE:  reg_rdata_o <= {4'h0, pulse_reg[1],
                                             pulse_reg[0], active_reg[1],
                                             active_reg[0]};
            default:         reg_rdata_o <= '0;
         endcase
      end
   end

   // Checks on the selection behaviour.
   property p_run_follow;
      @(posedge clk_i) disable iff (!resetn_i)
      (sel_reg[0] == FN_RUN) |=>
         (first_open_collector_output_oen_o == !$past(drive_running_i));
   endproperty
   a_run_follow: assert property (p_run_follow)
      else $error("first output does not follow running state");

   property p_overload_second;
      @(posedge clk_i) disable iff (!resetn_i)
      (sel_reg[1] == FN_OVERLOAD && overload_flag_i) |=>
         !second_open_collector_output_oen_o;
   endproperty
   a_overload_second: assert property (p_overload_second)
      else $error("second output missed overload");

   property p_spec_count;
      @(posedge clk_i) disable iff (!resetn_i)
      (sel_reg[0] == FN_SPEC_COUNT) |=>
         (active_reg[0] == $past(spec_count_reached_i));
   endproperty
   a_spec_count: assert property (p_spec_count)
      else $error("specified count indication wrong");

   property p_length;
      @(posedge clk_i) disable iff (!resetn_i)
      (sel_reg[0] == FN_LENGTH) |=>
         (active_reg[0] == ($past(measured_length_value_i) >=
                            $past(set_length_param_i)));
   endproperty
   a_length: assert property (p_length)
      else $error("length arrival indication wrong");

   property p_ready;
      @(posedge clk_i) disable iff (!resetn_i)
      (sel_reg[1] == FN_READY) |=>
         (active_reg[1] == (!$past(drive_fault_i) &&
                            $past(bus_voltage_ok_i) &&
                            !$past(run_prohibit_i)));
   endproperty
   a_ready: assert property (p_ready)
      else $error("ready indication wrong");

   property p_run_time;
      @(posedge clk_i) disable iff (!resetn_i)
      (sel_reg[1] == FN_RUN_TIME &&
       accumulated_run_time_i < run_cutoff_time_param_i) |=>
         !active_reg[1];
   endproperty
   a_run_time: assert property (p_run_time)
      else $error("run time indication before cutoff");

   property p_burst;
      @(posedge clk_i) disable iff (!resetn_i)
      (sel_reg[0] == FN_PIPE_BURST && pipe_burst_i) ##1
      (sel_reg[0] == FN_PIPE_BURST && pipe_burst_i) |->
         !first_open_collector_output_oen_o;
   endproperty
   a_burst: assert property (p_burst)
      else $error("pipe burst not shown");

   property p_reserved_off;
      @(posedge clk_i) disable iff (!resetn_i)
      (sel_reg[1] == FN_NONE || sel_reg[1] == FN_RESERVED_A ||
       sel_reg[1] == FN_RESERVED_B) |=> !active_reg[1];
   endproperty
   a_reserved_off: assert property (p_reserved_off)
      else $error("reserved code drives the output");

   property p_reject;
      @(posedge clk_i) disable iff (!resetn_i)
      (wr_sel_first && reg_wdata_i[4:0] > FN_MAX) |=>
         (sel_reg[0] == $past(sel_reg[0])) && int_status_reg[INT_REJECT];
   endproperty
   a_reject: assert property (p_reject)
      else $error("out of range code accepted");

   property p_pulse_start;
      @(posedge clk_i) disable iff (!resetn_i)
      (!pulse_reg[0] && phase_done_event_i) |=>
         pulse_reg[0] ##1 pulse_reg[0];
   endproperty
   a_pulse_start: assert property (p_pulse_start)
      else $error("phase pulse did not start or ended early");

   property p_pulse_end;
      @(posedge clk_i) disable iff (!resetn_i)
      (pulse_reg[1] && pulse_cnt_reg[1] == pulse_last) |=>
         !pulse_reg[1];
   endproperty
   a_pulse_end: assert property (p_pulse_end)
      else $error("cycle pulse exceeds its width");

   property p_fault;
      @(posedge clk_i) disable iff (!resetn_i)
      (sel_reg[0] == FN_FAULT) |=>
         (active_reg[0] == $past(drive_fault_i));
   endproperty
   a_fault: assert property (p_fault)
      else $error("fault indication wrong");

   property p_forward;
      @(posedge clk_i) disable iff (!resetn_i)
      (sel_reg[0] == FN_FORWARD) |=>
         (active_reg[0] == $past(forward_running_i));
   endproperty
   a_forward: assert property (p_forward)
      else $error("forward running indication wrong");

   property p_reverse;
      @(posedge clk_i) disable iff (!resetn_i)
      (sel_reg[0] == FN_REVERSE) |=>
         (active_reg[0] == $past(reverse_running_i));
   endproperty
   a_reverse: assert property (p_reverse)
      else $error("reverse running indication wrong");

   property p_sleep;
      @(posedge clk_i) disable iff (!resetn_i)
      (sel_reg[0] == FN_SLEEP) |=>
         (active_reg[0] == $past(supply_sleep_i));
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("sleep indication wrong");

   property p_overpressure;
      @(posedge clk_i) disable iff (!resetn_i)
      (sel_reg[0] == FN_OVERPRESSURE) |=>
         (active_reg[0] == $past(pipe_overpressure_i));
   endproperty
   a_overpressure: assert property (p_overpressure)
      else $error("overpressure indication wrong");

   property p_underpressure;
      @(posedge clk_i) disable iff (!resetn_i)
      (sel_reg[0] == FN_UNDERPRESS) |=>
         (active_reg[0] == $past(pipe_underpressure_i));
   endproperty
   a_underpressure: assert property (p_underpressure)
      else $error("under-pressure indication wrong");

endmodule // ofs_output_function_selector

// ### sim/ofs_field_model.sv
// Field equipment model: pull-up loads on the two open-collector terminals.
`timescale 1ns/1ps
module ofs_field_model (
   input  wire logic oc1_i,
   input  wire logic oc1_oen_i,
   input  wire logic oc2_i,
   input  wire logic oc2_oen_i,
   output logic      line1_o,
   output logic      line2_o
);
   // A released terminal floats to the pull-up level, never the last value.
   assign line1_o = oc1_oen_i ? 1'b1 : oc1_i;
   assign line2_o = oc2_oen_i ? 1'b1 : oc2_i;
endmodule // ofs_field_model

// ### sim/tb_output_function_selector.sv
// Self-checking bench for the output function selector.
`timescale 1ns/1ps
module tb_output_function_selector
   import ofs_pkg::*;
;
   localparam int PC = 8;
   logic             clk_i = 1'b0;
   logic             resetn_i = 1'b0;
   logic [3:0]       addr = 4'h0;
   logic [7:0]       wdata = 8'h00;
   logic             wr = 1'b0;
   logic             rd = 1'b0;
   logic [28:0]      cnd = 29'h0;
   logic             ev_ph = 1'b0;
   logic             ev_cy = 1'b0;
   logic             bus_ok = 1'b1;
   logic             proh = 1'b0;
   logic [15:0]      len = 16'h0;
   logic [15:0]      setl = 16'h0;
   wire logic [7:0]  rdata;
   wire logic        o1, e1, o2, e2, irq, l1, l2;
   int               err_count = 0;
   int               samples_checked = 0;
   int               cyc = 0;
   int               n;
   int               rsv [3] = '{0, 18, 22};
   logic [7:0]       bad [3] = '{8'h1d, 8'h21, 8'hff};

   ofs_output_function_selector #(.PULSE_CYCLES(PC)) dut_u (
      .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .drive_running_i(cnd[1]),
      .freq_reached_flag_i(cnd[2]), .freq_level_detect_one_i(cnd[3]),
      .freq_level_detect_two_i(cnd[4]), .overload_flag_i(cnd[5]),
      .undervoltage_lockout_flag_i(cnd[6]),
      .external_fault_flag_i(cnd[7]), .freq_upper_limit_flag_i(cnd[8]),
      .freq_lower_limit_flag_i(cnd[9]), .zero_freq_running_i(cnd[10]),
      .phase_done_event_i(ev_ph), .cycle_done_event_i(ev_cy),
      .set_count_reached_i(cnd[13]), .spec_count_reached_i(cnd[14]),
      .measured_length_value_i(len), .set_length_param_i(setl),
      .drive_fault_i(cnd[17]), .bus_voltage_ok_i(bus_ok),
      .run_prohibit_i(proh), .accumulated_run_time_i(len),
      .run_cutoff_time_param_i(setl), .forward_running_i(cnd[20]),
      .reverse_running_i(cnd[21]), .supply_sleep_i(cnd[23]),
      .pipe_overpressure_i(cnd[24]), .pipe_underpressure_i(cnd[25]),
      .pipe_short_i(cnd[26]), .tank_short_i(cnd[27]),
      .pipe_burst_i(cnd[28]), .first_open_collector_output_o(o1),
      .first_open_collector_output_oen_o(e1),
      .second_open_collector_output_o(o2),
      .second_open_collector_output_oen_o(e2), .irq_o(irq));

   ofs_field_model field_u (.oc1_i(o1), .oc1_oen_i(e1), .oc2_i(o2),
      .oc2_oen_i(e2), .line1_o(l1), .line2_o(l2));

   // Free-running 100 MHz clock.
   initial begin
      forever #5 clk_i = ~clk_i;
   end

   // Hang guard: the whole sequence needs well under this many cycles.
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_count++;
         $display("wrong value at %0t: run timed out", $time);
         conclude();
      end
   end

   task automatic conclude();
      if (err_count == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One-cycle write strobe; the slave never stalls.
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   // A terminal that is on pulls its line low.
   task automatic out_chk(input logic on1, input logic on2);
      repeat (3) @(posedge clk_i);
      #1;
      chk({6'h0, l2, l1}, {6'h0, !on2, !on1});
      // Return on an edge so the caller's next stimulus lands on it.
      @(posedge clk_i);
   endtask

   initial begin
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd_chk(ADDR_SEL_FIRST, 8'h00);
      rd_chk(ADDR_SEL_SECOND, 8'h01);
      rd_chk(ADDR_INT_STATUS, 8'h00);
      rd_chk(ADDR_INT_MASK, 8'h00);
      rd_chk(4'hf, 8'h00);
      // Each single-input level code: every other condition set, then its own alone.
      for (int c = 1; c <= 28; c++) begin
         if (c inside {11, 12, 15, 16, 18, 19, 22}) continue;
         wr_reg(ADDR_SEL_FIRST, 8'(c));
         cnd <= ~(29'h1 << c) & 29'h1fffe7fe;
         out_chk(1'b0, c != 1);
         cnd <= 29'h1 << c;
         out_chk(1'b1, c == 1);
      end
      // Length and running time around the threshold of 0x0100.
      cnd <= 29'h0;
      setl <= 16'h0100;
      for (int k = 0; k < 2; k++) begin
         wr_reg(ADDR_SEL_FIRST, k ? 8'h13 : 8'h0f);
         wr_reg(ADDR_SEL_SECOND, k ? 8'h13 : 8'h0f);
         for (int v = 0; v < 3; v++) begin
            len <= 16'h00ff + 16'(v);
            out_chk(v > 0, v > 0);
         end
      end
      // Ready needs no fault, a normal bus and no prohibit.
      wr_reg(ADDR_SEL_FIRST, 8'h10);
      wr_reg(ADDR_SEL_SECOND, 8'h10);
      for (int i = 0; i < 8; i++) begin
         cnd[17] <= i[0];
         bus_ok <= i[1];
         proh <= i[2];
         out_chk(i == 2, i == 2);
      end
      // Both outputs have switched on by now, no write was refused.
      rd_chk(ADDR_INT_STATUS, 8'h03);
      // Completion pulses: exact width, a second event inside is ignored.
      for (int k = 0; k < 2; k++) begin
         wr_reg(ADDR_SEL_FIRST, k ? 8'h0c : 8'h0b);
         @(posedge clk_i);
         ev_ph <= !k;
         ev_cy <= k;
         @(posedge clk_i);
         ev_ph <= 1'b0;
         ev_cy <= 1'b0;
         n = 0;
         for (int i = 0; i < 30; i++) begin
            @(posedge clk_i);
            ev_ph <= (i == 3) && !k;
            ev_cy <= (i == 3) && k;
            #1;
            if (l1 === 1'b0) n++;
         end
         chk(n[7:0], 8'(PC));
      end
      // Off codes hold both terminals off with every level condition but ready, plus length and run time, true.
      @(posedge clk_i);
      cnd <= 29'h1fffe7fe;
      len <= 16'h0200;
      foreach (rsv[i]) begin
         wr_reg(ADDR_SEL_FIRST, 8'(rsv[i]));
         wr_reg(ADDR_SEL_SECOND, 8'(rsv[i]));
         out_chk(1'b0, 1'b0);
      end
      // Rejected selections leave the code and flag status bit 2.
      cnd <= 29'h0;
      wr_reg(ADDR_INT_STATUS, 8'h07);
      foreach (bad[i]) begin
         wr_reg(ADDR_SEL_FIRST, bad[i]);
         rd_chk(ADDR_SEL_FIRST, 8'h16);
         rd_chk(ADDR_INT_STATUS, 8'h04);
         wr_reg(ADDR_INT_STATUS, 8'h04);
      end
      // Interrupt: masked, unmasked, cleared, then an output rise.
      wr_reg(ADDR_SEL_FIRST, 8'h1d);
      #1;
      chk({7'h0, irq}, 8'h00);
      wr_reg(ADDR_INT_MASK, 8'h04);
      #1;
      chk({7'h0, irq}, 8'h01);
      wr_reg(ADDR_INT_STATUS, 8'h04);
      #1;
      chk({7'h0, irq}, 8'h00);
      wr_reg(ADDR_SEL_SECOND, 8'h01);
      cnd[1] <= 1'b1;
      out_chk(1'b0, 1'b1);
      rd_chk(ADDR_INT_STATUS, 8'h02);
      wr_reg(ADDR_OUT_STATE, 8'h00);
      rd_chk(ADDR_OUT_STATE, 8'h02);
      chk({7'h0, irq}, 8'h00);
      wr_reg(ADDR_INT_MASK, 8'h02);
      #1;
      chk({7'h0, irq}, 8'h01);
      // Second output held on by overload alone, running dropped.
      wr_reg(ADDR_SEL_SECOND, 8'h05);
      cnd <= 29'h20;
      out_chk(1'b0, 1'b1);
      conclude();
   end
endmodule // tb_output_function_selector
